// ===== design/sdss_consts.vh
`ifndef SDSS_CONSTS_VH
`define SDSS_CONSTS_VH

// Link state codes as seen by the master.
`define SDSS_LINK_INIT      4'h1
`define SDSS_LINK_PREOP     4'h2
`define SDSS_LINK_SAFEOP    4'h4
`define SDSS_LINK_OP        4'h8

// Distributed clock example setup.
`define SDSS_SYNC_TYPE_DC   16'h0002
`define SDSS_DC_CYCLE_NS    32'h001E8480
`define SDSS_DC_SHIFT_NS    32'h00000000
`define SDSS_CLK_PERIOD_NS  32'h00000032
`define SDSS_DC_CYCLE_CLKS  (`SDSS_DC_CYCLE_NS / `SDSS_CLK_PERIOD_NS)

// Operation mode that selects profile position moves.
`define SDSS_MODE_PROFPOS   8'h01

// Command word masks and patterns.
`define SDSS_CW_MASK_SHUT   16'h0087
`define SDSS_CW_SHUTDOWN    16'h0006
`define SDSS_CW_MASK_ON     16'h008F
`define SDSS_CW_SWITCH_ON   16'h0007
`define SDSS_CW_ENABLE_OP   16'h000F
`define SDSS_CW_BIT_SETPT   4
`define SDSS_CW_BIT_FRESET  7

// State word low bytes per power-stage state.
`define SDSS_SW_SOD         8'h40
`define SDSS_SW_RTSO        8'h21
`define SDSS_SW_SO          8'h23
`define SDSS_SW_OE          8'h27
`define SDSS_SW_REACT       8'h0F
`define SDSS_SW_FAULT       8'h08
`define SDSS_SW_BIT_VOLT    4
`define SDSS_SW_BIT_REACHED 10
`define SDSS_SW_BIT_LIMIT   11
`define SDSS_SW_BIT_SETACK  12

// Limit object slots in the object memory.
`define SDSS_OBJ_MAX_PVEL   3'h0
`define SDSS_OBJ_MAX_MSPD   3'h1
`define SDSS_OBJ_MAX_ACC    3'h2
`define SDSS_OBJ_MAX_DEC    3'h3
`define SDSS_OBJ_POS_MIN    3'h4
`define SDSS_OBJ_POS_MAX    3'h5
`define SDSS_OBJ_QSTOP_DEC  3'h6
`define SDSS_OBJ_FAULT_DEC  3'h7

// Alias source setting that selects the rotary switch.
`define SDSS_ALIAS_FROM_RSW 16'h0000

`endif

// ===== design/sdss_obj_mem.v
`timescale 1ns/10ps
module sdss_obj_mem #(
  parameter AW = 3,
  parameter DW = 32
) (
  input  wire          clk,     // System clock.
  input  wire          wrEn,    // Write strobe.
  input  wire [AW-1:0] wrAddr,  // Write slot.
  input  wire [DW-1:0] wrData,  // Write value.
  input  wire [AW-1:0] rdAddr,  // Read slot.
  output reg  [DW-1:0] rdData   // Registered read value.
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Plain synchronous RAM; contents are undefined until software writes them.
  always @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

// ===== design/sdss_sequencer.v
`timescale 1ns/10ps
`include "sdss_consts.vh"
module sdss_sequencer #(
  parameter SYNC_CLKS = `SDSS_DC_CYCLE_CLKS
) (
  input  wire        clk,           // System clock, 20 MHz.
  input  wire        rstn,          // Asynchronous reset, active low.
  input  wire        linkReqStb,    // Link state request strobe.
  input  wire [3:0]  linkReqState,  // Requested link state code.
  input  wire        mbxCfgDone,    // Mailbox channels configured.
  input  wire        pdoCfgDone,    // Process-data channels configured.
  input  wire [15:0] dcSyncType0,   // Output sync type.
  input  wire [15:0] dcSyncType1,   // Input sync type.
  input  wire [31:0] dcCycleNs,     // Sync cycle time in ns.
  input  wire [31:0] dcShiftNs,     // Input latch shift in ns.
  input  wire        ctrlStb,       // Command word strobe.
  input  wire [15:0] ctrlWord,      // Command word.
  input  wire        modeStb,       // Operation mode write strobe.
  input  wire [7:0]  modeValue,     // Operation mode value.
  input  wire [31:0] moveTarget,    // Requested target position.
  input  wire [31:0] moveVel,       // Requested profile velocity.
  input  wire [31:0] moveAcc,       // Requested profile acceleration.
  input  wire [31:0] moveDec,       // Requested profile deceleration.
  input  wire        objWrStb,      // Limit object write strobe.
  input  wire [2:0]  objWrIdx,      // Limit object slot.
  input  wire [31:0] objWrData,     // Limit object value.
  input  wire        posLimEnable,  // Software position limit enabled.
  input  wire        mainPower,     // Main circuit power present.
  input  wire        netAlarm,      // Network-related alarm active.
  input  wire        overtravel,    // Overtravel inhibit input.
  input  wire        moveDone,      // Motion generator has stopped.
  input  wire [7:0]  rotarySwitch,  // Front rotary alias switches.
  input  wire [15:0] aliasSource,   // Stored alias source setting.
  input  wire [15:0] eepromAlias,   // Alias from the info EEPROM.
  output reg  [3:0]  linkState,     // Current link state code.
  output reg         linkRefused,   // Last link request refused.
  output reg         syncTick,      // One pulse per sync cycle.
  output reg  [15:0] statusWord,    // Drive state word.
  output reg         servoOn,       // Power stage energised.
  output reg  [7:0]  modeActive,    // Operation mode in force.
  output reg         moveStart,     // One-cycle move start pulse.
  output reg  [31:0] cmdTarget,     // Clamped target position.
  output reg  [31:0] cmdVel,        // Clamped profile velocity.
  output reg  [31:0] cmdAcc,        // Clamped acceleration.
  output reg  [31:0] cmdDec,        // Clamped deceleration.
  output reg         stopActive,    // Forced stop in progress.
  output reg  [31:0] stopDecel,     // Deceleration for forced stop.
  output reg  [15:0] stationAlias   // Alias offered to the master.
);

  // Power-stage states, one-hot.
  localparam [5:0] PS_SOD   = 6'h01;
  localparam [5:0] PS_RTSO  = 6'h02;
  localparam [5:0] PS_SO    = 6'h04;
  localparam [5:0] PS_OE    = 6'h08;
  localparam [5:0] PS_FAULT = 6'h10;
  localparam [5:0] PS_REACT = 6'h20;

  reg  [5:0]  psState;
  reg  [5:0]  next_psState;
  reg  [3:0]  next_linkState;
  reg         next_linkRefused;
  reg  [2:0]  scanIdx;
  reg  [2:0]  scanPrev;
  wire [31:0] limShadow [0:7];
  reg         setPtPrev;
  reg         fResetPrev;
  reg         limitHeld;
  reg         aliasCaught;
  reg         useRotary;
  reg  [31:0] syncCnt;
  wire [31:0] memRd;

  // Limit objects live in a small RAM and are scanned into shadows.
  sdss_obj_mem #(
    .AW (3),
    .DW (32)
  ) uObjMem (
    .clk    (clk),
    .wrEn   (objWrStb),
    .wrAddr (objWrIdx),
    .wrData (objWrData),
    .rdAddr (scanIdx),
    .rdData (memRd)
  );

  // The scan adds up to nine cycles before a new limit takes effect.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scanIdx  <= 3'h0;
      scanPrev <= 3'h0;
    end
    else
    begin
      scanIdx  <= scanIdx + 3'h1;
      scanPrev <= scanIdx;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : gShadow
      localparam [2:0] SLOT = gi;
      reg [31:0] shadow;
      // Each shadow picks up its slot when the scan returns it; one register per slot avoids shared drivers.
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          shadow <= 32'h00000000;
        end
        else if (scanPrev == SLOT)
        begin
          shadow <= memRd;
        end
      end
      assign limShadow[gi] = shadow;
    end
  endgenerate

  // Distributed clock setup must match the example values exactly.
  wire dcOk = (dcSyncType0 == `SDSS_SYNC_TYPE_DC) && (dcSyncType1 == `SDSS_SYNC_TYPE_DC) &&
              (dcCycleNs == `SDSS_DC_CYCLE_NS) && (dcShiftNs == `SDSS_DC_SHIFT_NS);

  // Link state transitions; backward requests are always honoured.
  always @*
  begin
    next_linkState   = linkState;
    next_linkRefused = linkRefused;
    if (linkReqStb)
    begin
      next_linkRefused = 1'b1;
      case (linkReqState)
        `SDSS_LINK_INIT:
        begin
          next_linkState   = `SDSS_LINK_INIT;
          next_linkRefused = 1'b0;
        end
        `SDSS_LINK_PREOP:
        begin
          if ((linkState == `SDSS_LINK_INIT && mbxCfgDone) || linkState != `SDSS_LINK_INIT)
          begin
            next_linkState   = `SDSS_LINK_PREOP;
            next_linkRefused = 1'b0;
          end
        end
        `SDSS_LINK_SAFEOP:
        begin
          if ((linkState == `SDSS_LINK_PREOP && dcOk && pdoCfgDone) ||
              linkState == `SDSS_LINK_OP || linkState == `SDSS_LINK_SAFEOP)
          begin
            next_linkState   = `SDSS_LINK_SAFEOP;
            next_linkRefused = 1'b0;
          end
        end
        `SDSS_LINK_OP:
        begin
          if (linkState == `SDSS_LINK_SAFEOP || linkState == `SDSS_LINK_OP)
          begin
            next_linkState   = `SDSS_LINK_OP;
            next_linkRefused = 1'b0;
          end
        end
        default:
        begin
          next_linkState = linkState;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      linkState   <= `SDSS_LINK_INIT;
      linkRefused <= 1'b0;
    end
    else
    begin
      linkState   <= next_linkState;
      linkRefused <= next_linkRefused;
    end
  end

  // Sync tick runs once the process-data channels are live.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncCnt  <= 32'h00000000;
      syncTick <= 1'b0;
    end
    else if (linkState == `SDSS_LINK_SAFEOP || linkState == `SDSS_LINK_OP)
    begin
      syncTick <= (syncCnt == SYNC_CLKS - 1);
      syncCnt  <= (syncCnt == SYNC_CLKS - 1) ? 32'h00000000 : syncCnt + 32'h00000001;
    end
    else
    begin
      syncCnt  <= 32'h00000000;
      syncTick <= 1'b0;
    end
  end

  // Command decode; a link drop out of OP counts as a network alarm.
  wire cwShut   = ctrlStb && ((ctrlWord & `SDSS_CW_MASK_SHUT) == `SDSS_CW_SHUTDOWN);
  wire cwOn     = ctrlStb && ((ctrlWord & `SDSS_CW_MASK_ON) == `SDSS_CW_SWITCH_ON);
  wire cwEnable = ctrlStb && ((ctrlWord & `SDSS_CW_MASK_ON) == `SDSS_CW_ENABLE_OP);
  wire fReset   = ctrlStb && ctrlWord[`SDSS_CW_BIT_FRESET] && !fResetPrev;
  wire alarmNow = netAlarm || (linkState == `SDSS_LINK_OP && next_linkState != `SDSS_LINK_OP);

  always @*
  begin
    next_psState = psState;
    case (psState)
      PS_SOD:
      begin
        if (cwShut)
        begin
          next_psState = PS_RTSO;
        end
      end
      PS_RTSO:
      begin
        if (cwOn)
        begin
          next_psState = PS_SO;
        end
      end
      PS_SO:
      begin
        if (cwEnable)
        begin
          next_psState = PS_OE;
        end
      end
      PS_OE:
      begin
        if (alarmNow)
        begin
          next_psState = PS_REACT;
        end
        else if (cwOn)
        begin
          next_psState = PS_SO;
        end
      end
      PS_REACT:
      begin
        if (moveDone)
        begin
          next_psState = PS_FAULT;
        end
      end
      PS_FAULT:
      begin
        if (fReset && !netAlarm)
        begin
          next_psState = PS_SOD;
        end
      end
      default:
      begin
        next_psState = PS_SOD;
      end
    endcase
    if (alarmNow && psState != PS_OE && psState != PS_REACT)
    begin
      next_psState = PS_FAULT;
    end
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      psState    <= PS_SOD;
      servoOn    <= 1'b0;
      fResetPrev <= 1'b0;
    end
    else
    begin
      psState    <= next_psState;
      servoOn    <= (next_psState == PS_OE) || (next_psState == PS_REACT);
      if (ctrlStb)
      begin
        fResetPrev <= ctrlWord[`SDSS_CW_BIT_FRESET];
      end
    end
  end

  // Operation mode; only profile position moves are executed here.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      modeActive <= 8'h00;
    end
    else if (modeStb)
    begin
      modeActive <= modeValue;
    end
  end

  // Clamp candidates for the next move.
  wire [31:0] velCap  = (limShadow[`SDSS_OBJ_MAX_PVEL] < limShadow[`SDSS_OBJ_MAX_MSPD]) ?
                        limShadow[`SDSS_OBJ_MAX_PVEL] : limShadow[`SDSS_OBJ_MAX_MSPD];
  wire        velClip = moveVel > velCap;
  wire        accClip = moveAcc > limShadow[`SDSS_OBJ_MAX_ACC];
  wire        decClip = moveDec > limShadow[`SDSS_OBJ_MAX_DEC];
  wire        posLo   = posLimEnable && ($signed(moveTarget) < $signed(limShadow[`SDSS_OBJ_POS_MIN]));
  wire        posHi   = posLimEnable && ($signed(moveTarget) > $signed(limShadow[`SDSS_OBJ_POS_MAX]));
  wire        setPtUp = ctrlStb && ctrlWord[`SDSS_CW_BIT_SETPT] && !setPtPrev;
  wire        ppGo    = setPtUp && psState == PS_OE && !alarmNow &&
                        modeActive == `SDSS_MODE_PROFPOS;

  // A move latches clamped values; the limit flag holds for that move.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      setPtPrev <= 1'b0;
      moveStart <= 1'b0;
      limitHeld <= 1'b0;
      cmdTarget <= 32'h00000000;
      cmdVel    <= 32'h00000000;
      cmdAcc    <= 32'h00000000;
      cmdDec    <= 32'h00000000;
    end
    else
    begin
      if (ctrlStb)
      begin
        setPtPrev <= ctrlWord[`SDSS_CW_BIT_SETPT];
      end
      moveStart <= ppGo;
      if (ppGo)
      begin
        cmdTarget <= posLo ? limShadow[`SDSS_OBJ_POS_MIN] :
                     (posHi ? limShadow[`SDSS_OBJ_POS_MAX] : moveTarget);
        cmdVel    <= velClip ? velCap : moveVel;
        cmdAcc    <= accClip ? limShadow[`SDSS_OBJ_MAX_ACC] : moveAcc;
        cmdDec    <= decClip ? limShadow[`SDSS_OBJ_MAX_DEC] : moveDec;
        limitHeld <= velClip || accClip || decClip || posLo || posHi;
      end
      else if (moveDone)
      begin
        limitHeld <= 1'b0;
      end
    end
  end

  // Forced stop: fault reaction outranks overtravel.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stopActive <= 1'b0;
      stopDecel  <= 32'h00000000;
    end
    else if (next_psState == PS_REACT)
    begin
      stopActive <= 1'b1;
      stopDecel  <= limShadow[`SDSS_OBJ_FAULT_DEC];
    end
    else if (overtravel && next_psState == PS_OE)
    begin
      stopActive <= 1'b1;
      stopDecel  <= limShadow[`SDSS_OBJ_QSTOP_DEC];
    end
    else
    begin
      stopActive <= 1'b0;
      stopDecel  <= 32'h00000000;
    end
  end

  // State word assembled from the next state so it settles with servoOn.
  reg [7:0] swLow;
  always @*
  begin
    case (next_psState)
      PS_SOD:   swLow = `SDSS_SW_SOD;
      PS_RTSO:  swLow = `SDSS_SW_RTSO;
      PS_SO:    swLow = `SDSS_SW_SO;
      PS_OE:    swLow = `SDSS_SW_OE;
      PS_REACT: swLow = `SDSS_SW_REACT;
      PS_FAULT: swLow = `SDSS_SW_FAULT;
      default:  swLow = `SDSS_SW_SOD;
    endcase
    swLow[`SDSS_SW_BIT_VOLT] = mainPower;
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      statusWord <= {8'h00, `SDSS_SW_SOD};
    end
    else
    begin
      statusWord <= {3'h0, moveStart, (limitHeld && !moveDone) || stopActive,
                     moveDone && !moveStart, 2'h0, swLow};
    end
  end

  // Alias source is caught once after reset, standing in for a power cycle.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aliasCaught  <= 1'b0;
      useRotary    <= 1'b0;
      stationAlias <= 16'h0000;
    end
    else
    begin
      if (!aliasCaught)
      begin
        aliasCaught <= 1'b1;
        useRotary   <= (aliasSource == `SDSS_ALIAS_FROM_RSW);
      end
      stationAlias <= useRotary ? {8'h00, rotarySwitch} : eepromAlias;
    end
  end

endmodule

// ===== verif/sdss_chk_assertions.sv
`timescale 1ns/10ps
`include "sdss_consts.vh"
module sdss_chk #(
  parameter SYNC_CLKS = 8
) (
  input wire        clk,          // System clock.
  input wire        rstn,         // Reset, active low.
  input wire        linkReqStb,   // Link request strobe.
  input wire [3:0]  linkReqState, // Requested link state.
  input wire        ctrlStb,      // Command strobe.
  input wire [15:0] ctrlWord,     // Command word.
  input wire        netAlarm,     // Network alarm.
  input wire        overtravel,   // Overtravel input.
  input wire        mainPower,    // Main power.
  input wire [3:0]  linkState,    // Link state.
  input wire        linkRefused,  // Refusal flag.
  input wire        syncTick,     // Sync pulse.
  input wire [15:0] statusWord,   // State word.
  input wire        servoOn,      // Servo on.
  input wire [7:0]  modeActive,   // Mode in force.
  input wire        moveStart,    // Move start pulse.
  input wire        stopActive    // Forced stop.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // The voltage bit is masked so state checks hold with or without main power.
  wire [7:0] pdsState = statusWord[7:0] & 8'hEF;
  wire       quiet    = !netAlarm && !overtravel;
  reg        lastBit4;
  // The set point is an edge across successive command words, so the last bit 4 is kept.
  always @(posedge clk or negedge rstn)
    if (!rstn)
      lastBit4 <= 1'b0;
    else if (ctrlStb)
      lastBit4 <= ctrlWord[4];
  shutdown_step_a: assert property (
    ctrlStb && ctrlWord == `SDSS_CW_SHUTDOWN && pdsState == `SDSS_SW_SOD && quiet
    |=> pdsState == `SDSS_SW_RTSO) else $error("shutdown step missed");
  switch_on_a: assert property (
    ctrlStb && ctrlWord == `SDSS_CW_SWITCH_ON && pdsState == `SDSS_SW_RTSO && quiet
    |=> pdsState == `SDSS_SW_SO) else $error("switch on step missed");
  enable_op_a: assert property (
    ctrlStb && ctrlWord == `SDSS_CW_ENABLE_OP && pdsState == `SDSS_SW_SO && quiet
    |=> pdsState == `SDSS_SW_OE && servoOn) else $error("enable step missed");
  disable_op_a: assert property (
    ctrlStb && ctrlWord == `SDSS_CW_SWITCH_ON && pdsState == `SDSS_SW_OE && quiet
    |=> pdsState == `SDSS_SW_SO && !servoOn) else $error("disable step missed");
  invalid_cmd_a: assert property (
    ctrlStb && ctrlWord == `SDSS_CW_ENABLE_OP && pdsState == `SDSS_SW_SOD && quiet
    |=> $stable(statusWord[7:0])) else $error("invalid command changed state");
  volt_bit_a: assert property (
    $changed(mainPower) |=> statusWord[4] == $past(mainPower)) else $error("voltage bit wrong");
  move_start_a: assert property (
    ctrlStb && ctrlWord[4] && !lastBit4 && pdsState == `SDSS_SW_OE && modeActive == `SDSS_MODE_PROFPOS
    && !netAlarm |=> moveStart) else $error("move not started");
  alarm_stop_a: assert property (
    netAlarm && pdsState == `SDSS_SW_OE |-> ##[1:2] stopActive) else $error("alarm stop missing");
  link_refuse_a: assert property (
    linkReqStb && linkState == `SDSS_LINK_INIT && linkReqState == `SDSS_LINK_OP
    |=> linkRefused && linkState == `SDSS_LINK_INIT) else $error("bad link step taken");
  sync_period_a: assert property (
    SYNC_CLKS == 8 && syncTick && linkState == `SDSS_LINK_OP |=> (!syncTick)[*7] ##1 syncTick)
    else $error("sync period wrong");
endmodule
bind sdss_sequencer sdss_chk #(.SYNC_CLKS(SYNC_CLKS)) chk (.clk, .rstn, .linkReqStb, .linkReqState, .ctrlStb,
  .ctrlWord, .netAlarm, .overtravel, .mainPower, .linkState, .linkRefused, .syncTick, .statusWord, .servoOn,
  .modeActive, .moveStart, .stopActive);

// ===== verif/sdss_host_model.sv
`timescale 1ns/10ps
`include "sdss_consts.vh"
module sdss_host_model (
  input  wire        clk,          // System clock.
  input  wire        go,           // Start bring-up.
  input  wire        tryBad,       // Ask for OP from Init first.
  input  wire [3:0]  linkState,    // Link state seen.
  input  wire [15:0] stationAlias, // Alias offered.
  output logic        linkReqStb,   // Link request strobe.
  output logic [3:0]  linkReqState, // Requested state.
  output logic        mbxCfgDone,   // Mailbox set up.
  output logic        pdoCfgDone,   // Process data set up.
  output logic [15:0] dcSyncType0,  // Output sync type.
  output logic [15:0] dcSyncType1,  // Input sync type.
  output logic [31:0] dcCycleNs,    // Cycle time.
  output logic [31:0] dcShiftNs,    // Latch shift.
  output logic [15:0] stationAddr,  // Copied address.
  output logic        done          // Bring-up finished.
);
  // A request that is not confirmed is sent again, up to three sends in all.
  task req(input logic [3:0] code);
    integer n;
    for (n = 0; n < 3 && linkState !== code; n++)
    begin
      @(posedge clk);
      linkReqStb <= 1'b1;
      linkReqState <= code;
      @(posedge clk);
      linkReqStb <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // Bring-up walks Init, PreOP, SafeOP and OP, confirming each step.
  initial
  begin
    linkReqStb = 1'b0;
    linkReqState = `SDSS_LINK_INIT;
    mbxCfgDone = 1'b0;
    pdoCfgDone = 1'b0;
    dcSyncType0 = 16'h0000;
    dcSyncType1 = 16'h0000;
    dcCycleNs = 32'h00000000;
    dcShiftNs = 32'h00000000;
    stationAddr = 16'h0000;
    done = 1'b0;
    wait (go === 1'b1);
    if (tryBad)
      req(`SDSS_LINK_OP);
    @(posedge clk);
    stationAddr <= stationAlias;
    mbxCfgDone <= 1'b1;
    req(`SDSS_LINK_PREOP);
    @(posedge clk);
    dcSyncType0 <= `SDSS_SYNC_TYPE_DC;
    dcSyncType1 <= `SDSS_SYNC_TYPE_DC;
    dcCycleNs <= `SDSS_DC_CYCLE_NS;
    dcShiftNs <= `SDSS_DC_SHIFT_NS;
    pdoCfgDone <= 1'b1;
    if (linkState === `SDSS_LINK_PREOP)
      req(`SDSS_LINK_SAFEOP);
    if (linkState === `SDSS_LINK_SAFEOP)
      req(`SDSS_LINK_OP);
    done <= 1'b1;
  end
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`include "sdss_consts.vh"
module tb_top;
  logic        clk, rstn, go, done, tryBad, linkReqStb, mbxCfgDone, pdoCfgDone, ctrlStb, modeStb, objWrStb;
  logic        posLimEnable, mainPower, netAlarm, overtravel, moveDone;
  logic        linkRefused, syncTick, servoOn, moveStart, stopActive;
  logic [3:0]  linkReqState, linkState;
  logic [2:0]  objWrIdx;
  logic [7:0]  modeValue, rotarySwitch, modeActive;
  logic [15:0] dcSyncType0, dcSyncType1, ctrlWord, aliasSource, eepromAlias, statusWord, stationAlias, stationAddr;
  logic [31:0] dcCycleNs, dcShiftNs, moveTarget, moveVel, moveAcc, moveDec, objWrData;
  logic [31:0] cmdTarget, cmdVel, cmdAcc, cmdDec, stopDecel;
  logic [31:0] lim [0:7];
  integer      error_cnt, checks, i, n;
  integer      cyc = 0;
  sdss_sequencer #(.SYNC_CLKS(8)) uut (.clk, .rstn, .linkReqStb, .linkReqState, .mbxCfgDone, .pdoCfgDone,
    .dcSyncType0, .dcSyncType1, .dcCycleNs, .dcShiftNs, .ctrlStb, .ctrlWord, .modeStb, .modeValue,
    .moveTarget, .moveVel, .moveAcc, .moveDec, .objWrStb, .objWrIdx, .objWrData, .posLimEnable,
    .mainPower, .netAlarm, .overtravel, .moveDone, .rotarySwitch, .aliasSource, .eepromAlias,
    .linkState, .linkRefused, .syncTick, .statusWord, .servoOn, .modeActive, .moveStart,
    .cmdTarget, .cmdVel, .cmdAcc, .cmdDec, .stopActive, .stopDecel, .stationAlias);
  sdss_host_model host (.clk, .go, .tryBad, .linkState, .stationAlias, .linkReqStb, .linkReqState,
    .mbxCfgDone, .pdoCfgDone, .dcSyncType0, .dcSyncType1, .dcCycleNs, .dcShiftNs, .stationAddr, .done);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmd(input logic [15:0] w);
    @(posedge clk);
    ctrlStb <= 1'b1;
    ctrlWord <= w;
    @(posedge clk);
    ctrlStb <= 1'b0;
    @(negedge clk);
  endtask
  // The voltage bit is masked here; it has its own check.
  task power_stage_state_machine(input logic [15:0] w, input logic [7:0] exp);
    cmd(w);
    chk(statusWord[7:0] & 8'hEF, exp);
  endtask
  task settle(input logic [2:0] k);
    repeat (k) @(negedge clk);
  endtask
  task conclude;
    $display("error_cnt=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Free-running 20 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // A hang counts as a mismatch; the full run needs well under a thousand cycles.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  end
  // Main sequence: bring-up, power-stage walk, moves, stops and a second power-up.
  initial
  begin
    lim = '{32'h000003E8, 32'h00000320, 32'h0000012C, 32'h00000190,
            32'hFFFFFF9C, 32'h00001388, 32'h0000004D, 32'h00000063};
    {rstn, go, ctrlStb, modeStb, objWrStb, netAlarm, overtravel, moveDone} = 8'h00;
    {tryBad, posLimEnable, mainPower} = 3'h7;
    ctrlWord = 16'h0000;
    modeValue = 8'h00;
    objWrIdx = 3'h0;
    objWrData = 32'h00000000;
    {moveTarget, moveVel} = {32'h00002328, 32'h000007D0};
    {moveAcc, moveDec} = {32'h000001F4, 32'h00000064};
    rotarySwitch = 8'h5A;
    aliasSource = `SDSS_ALIAS_FROM_RSW;
    eepromAlias = 16'h1234;
    error_cnt = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    chk(statusWord, 16'h0040);
    rstn <= 1'b1;
    settle(3);
    chk(stationAlias, 16'h005A);
    @(posedge clk);
    go <= 1'b1;
    for (i = 0; i < 200 && done !== 1'b1; i++)
      @(posedge clk);
    settle(1);
    chk(linkState, `SDSS_LINK_OP);
    chk(stationAddr, 16'h005A);
    chk(linkRefused, 1'b0);
    n = 0;
    for (i = 0; i < 16; i++)
    begin
      @(negedge clk);
      n = n + (syncTick === 1'b1);
    end
    chk(n, 2);
    power_stage_state_machine(`SDSS_CW_ENABLE_OP, `SDSS_SW_SOD);
    power_stage_state_machine(`SDSS_CW_SHUTDOWN, `SDSS_SW_RTSO);
    power_stage_state_machine(`SDSS_CW_SWITCH_ON, `SDSS_SW_SO);
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      mainPower <= i[0];
      settle(2);
      chk(statusWord[4], i[0]);
    end
    @(posedge clk);
    modeStb <= 1'b1;
    modeValue <= `SDSS_MODE_PROFPOS;
    @(posedge clk);
    modeStb <= 1'b0;
    settle(1);
    chk(modeActive, 8'h01);
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      objWrStb <= 1'b1;
      objWrIdx <= i[2:0];
      objWrData <= lim[i];
    end
    @(posedge clk);
    objWrStb <= 1'b0;
    repeat (12) @(posedge clk);
    power_stage_state_machine(`SDSS_CW_ENABLE_OP, `SDSS_SW_OE);
    chk(servoOn, 1'b1);
    cmd(16'h001F);
    chk(moveStart, 1'b1);
    chk(cmdTarget, lim[5]);
    chk(cmdVel, lim[1]);
    chk(cmdAcc, lim[2]);
    chk(cmdDec, 32'h00000064);
    settle(1);
    chk(statusWord[11], 1'b1);
    cmd(`SDSS_CW_ENABLE_OP);
    @(posedge clk);
    moveTarget <= 32'hFFFFFE0C;
    moveDec <= 32'h000001F4;
    cmd(16'h001F);
    chk(cmdTarget, lim[4]);
    chk(cmdDec, lim[3]);
    @(posedge clk);
    overtravel <= 1'b1;
    settle(2);
    chk(stopActive, 1'b1);
    chk(stopDecel, lim[6]);
    @(posedge clk);
    overtravel <= 1'b0;
    power_stage_state_machine(`SDSS_CW_SWITCH_ON, `SDSS_SW_SO);
    chk(servoOn, 1'b0);
    power_stage_state_machine(`SDSS_CW_ENABLE_OP, `SDSS_SW_OE);
    @(posedge clk);
    netAlarm <= 1'b1;
    settle(2);
    chk(stopDecel, lim[7]);
    chk(statusWord[7:0] & 8'hEF, `SDSS_SW_REACT);
    @(posedge clk);
    moveDone <= 1'b1;
    settle(2);
    chk(statusWord[7:0] & 8'hEF, `SDSS_SW_FAULT);
    @(posedge clk);
    rstn <= 1'b0;
    aliasSource <= 16'h0001;
    netAlarm <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    settle(3);
    chk(stationAlias, 16'h1234);
    conclude;
  end
endmodule
